// ---- src/mac_defs.svh ----
`ifndef MAC_DEFS_SVH
`define MAC_DEFS_SVH
// datapath widths
`define MAC_OP_W 18
`define MAC_HALF_W 9
`define MAC_ACC_W 44
`define MAC_WIDE_W 46
`define MAC_STAGE_W 45
// operand d arithmetic shift distance
`define MAC_D_SHIFT 17
// dot-product scale of 512 as a left shift
`define MAC_DOT_SHIFT 9
// wide sum bit positions
`define MAC_SIGN_BIT 43
`define MAC_CARRY_BIT 44
`define MAC_TOP_BIT 45
// control register slots
`define MAC_CTRL_N 4
`define MAC_CTL_SHIFT 0
`define MAC_CTL_CASCADE 1
`define MAC_CTL_FEEDBACK 2
`define MAC_CTL_SUBTRACT 3
`endif

// ---- src/mac_pkg.sv ----
`include "mac_defs.svh"
package mac_pkg;
  typedef logic [`MAC_OP_W-1:0] operand_t;
  typedef logic [`MAC_ACC_W-1:0] acc_t;
  typedef logic signed [`MAC_WIDE_W-1:0] wide_t;
  typedef logic [`MAC_STAGE_W-1:0] stage_t;
  typedef logic [`MAC_CTRL_N-1:0] ctrl_t;
endpackage : mac_pkg

// ---- src/multiply_accumulate_18x18.sv ----
// Functional notes
// RULE_01 - dot select picks dot-product or normal mode
// RULE_02 - result is d plus carry plus c, plus/minus product
// RULE_03 - fabric ties c low nine bits to carry
// RULE_04 - operand d: cascade, fed-back result, or zero
// RULE_05 - shift sign-extends operand d right seventeen
// RULE_06 - feedback needs registered result, cascade select low
// RULE_07 - flag kind zero gives overflow or underflow
// RULE_08 - flag kind one gives adder carry extension
// RULE_09 - wide sum is forty-six bits, never overflows
// RULE_10 - cascade output always equals the result
// RULE_11 - cascade input comes from whole neighbour output
// RULE_12 - one rising clock updates every register
// RULE_13 - async clear zeroes all registers at once
// RULE_14 - control register: hold, load value, or input
// RULE_15 - bypassed control register is transparent, still gated
// RULE_16 - data register: hold, clear, or input
// RULE_17 - result and flag share controls; carry and c too
// RULE_18 - unused register groups tied bypass, clear, enable high
// RULE_19 - operands and sums are two's complement signed
`include "mac_defs.svh"
module multiply_accumulate_18x18 (
  input wire logic dot_product_select,
  input wire logic flag_kind_select,
  input wire logic transient_filter_enable,
  input wire logic clock,
  input wire logic async_clear_n,
  input wire mac_pkg::operand_t a,
  input wire logic a_bypass,
  input wire logic a_sync_clear_n,
  input wire logic a_en,
  input wire mac_pkg::operand_t b,
  input wire logic b_bypass,
  input wire logic b_sync_clear_n,
  input wire logic b_en,
  output mac_pkg::acc_t result,
  output logic overflow_or_carry_flag,
  input wire logic result_bypass,
  input wire logic result_sync_clear_n,
  input wire logic result_en,
  output mac_pkg::acc_t cascade_out,
  input wire logic carry_input,
  input wire mac_pkg::acc_t c,
  input wire logic c_bypass,
  input wire logic c_sync_clear_n,
  input wire logic c_en,
  input wire mac_pkg::acc_t cascade_in,
  input wire logic operand_d_shift,
  input wire logic operand_d_shift_bypass,
  input wire logic operand_d_shift_sync_load_n,
  input wire logic operand_d_shift_sync_load_value,
  input wire logic operand_d_shift_en,
  input wire logic cascade_select,
  input wire logic cascade_select_bypass,
  input wire logic cascade_select_sync_load_n,
  input wire logic cascade_select_sync_load_value,
  input wire logic cascade_select_en,
  input wire logic feedback_select,
  input wire logic feedback_select_bypass,
  input wire logic feedback_select_sync_load_n,
  input wire logic feedback_select_sync_load_value,
  input wire logic feedback_select_en,
  input wire logic subtract,
  input wire logic subtract_bypass,
  input wire logic subtract_sync_load_n,
  input wire logic subtract_sync_load_value,
  input wire logic subtract_en
);

  // shared stage: hold, forced load (clear or load value), or take input
  function automatic mac_pkg::stage_t stage_next(
    input logic en,
    input logic load_n,
    input mac_pkg::stage_t load_val,
    input mac_pkg::stage_t d,
    input mac_pkg::stage_t q
  );
    stage_next = en ? (load_n ? d : load_val) : q;
  endfunction : stage_next

  mac_pkg::operand_t a_q, a_d, a_v;
  mac_pkg::operand_t b_q, b_d, b_v;
  mac_pkg::acc_t c_q, c_d, c_v;
  logic cin_q, cin_d, cin_v;
  mac_pkg::acc_t p_q, p_d;
  logic flag_q, flag_d;
  mac_pkg::ctrl_t ctrl_q, ctrl_d, ctrl_v;
  mac_pkg::ctrl_t ctrl_in, ctrl_byp, ctrl_ld_n, ctrl_ld_val, ctrl_en;
  mac_pkg::stage_t c_stage, p_stage;
  mac_pkg::acc_t d_src, operand_d;
  logic signed [2*`MAC_OP_W-1:0] prod_norm;
  logic signed [2*`MAC_HALF_W-1:0] lo_hi, hi_lo;
  logic signed [2*`MAC_HALF_W:0] cross_sum;
  mac_pkg::wide_t product, wide_sum;
  logic flag_calc;

  // gather the four control registers into slots
  assign ctrl_in = {subtract, feedback_select, cascade_select,
                    operand_d_shift};
  assign ctrl_byp = {subtract_bypass, feedback_select_bypass,
                     cascade_select_bypass, operand_d_shift_bypass};
  assign ctrl_ld_n = {subtract_sync_load_n, feedback_select_sync_load_n,
                      cascade_select_sync_load_n,
                      operand_d_shift_sync_load_n};
  assign ctrl_ld_val = {subtract_sync_load_value,
                        feedback_select_sync_load_value,
                        cascade_select_sync_load_value,
                        operand_d_shift_sync_load_value};
  assign ctrl_en = {subtract_en, feedback_select_en, cascade_select_en,
                    operand_d_shift_en};

  // control register next values; load value is taken uninverted
  generate
    for (genvar i = 0; i < `MAC_CTRL_N; i++) begin : g_ctrl
      // RULE_14 hold or load
      always_comb begin
        ctrl_d[i] = ctrl_en[i] ? (ctrl_ld_n[i] ? ctrl_in[i]
                                               : ctrl_ld_val[i])
                               : ctrl_q[i];
      end
      // RULE_15 transparent when bypassed
      always_comb begin
        ctrl_v[i] = async_clear_n & (ctrl_byp[i] ? ctrl_d[i] : ctrl_q[i]);
      end
    end
  endgenerate

  // input data stages; carry and c share one set of controls
  always_comb begin
    // RULE_16 data stage behaviour
    a_d = a_en ? (a_sync_clear_n ? a : '0) : a_q;
    b_d = b_en ? (b_sync_clear_n ? b : '0) : b_q;
    // RULE_17 carry with c
    c_stage = stage_next(c_en, c_sync_clear_n, '0, {carry_input, c},
                         {cin_q, c_q});
    cin_d = c_stage[`MAC_ACC_W];
    c_d = c_stage[`MAC_ACC_W-1:0];
    // RULE_13 clear also masks bypassed paths
    a_v = !async_clear_n ? '0 : (a_bypass ? a_d : a_q);
    b_v = !async_clear_n ? '0 : (b_bypass ? b_d : b_q);
    c_v = !async_clear_n ? '0 : (c_bypass ? c_d : c_q);
    cin_v = async_clear_n & (c_bypass ? cin_d : cin_q);
  end

  // operand d select; feedback reads the stored result, never a bypass
  always_comb begin
    // RULE_04 d source priority
    if (ctrl_v[`MAC_CTL_CASCADE]) begin
      d_src = cascade_in;
    end else if (ctrl_v[`MAC_CTL_FEEDBACK]) begin
      d_src = p_q;
    end else begin
      d_src = '0;
    end
    // RULE_05 arithmetic shift
    operand_d = ctrl_v[`MAC_CTL_SHIFT]
              ? {{`MAC_D_SHIFT{d_src[`MAC_SIGN_BIT]}},
                 d_src[`MAC_ACC_W-1:`MAC_D_SHIFT]}
              : d_src;
  end

  // product term, signed halves in dot-product mode
  always_comb begin
    // RULE_19 signed operands
    prod_norm = $signed(a_v) * $signed(b_v);
    lo_hi = $signed(a_v[`MAC_HALF_W-1:0])
          * $signed(b_v[`MAC_OP_W-1:`MAC_HALF_W]);
    hi_lo = $signed(a_v[`MAC_OP_W-1:`MAC_HALF_W])
          * $signed(b_v[`MAC_HALF_W-1:0]);
    cross_sum = (2*`MAC_HALF_W+1)'(lo_hi) + (2*`MAC_HALF_W+1)'(hi_lo);
    // RULE_01 mode select
    if (dot_product_select) begin
      product = mac_pkg::wide_t'(cross_sum) <<< `MAC_DOT_SHIFT;
    end else begin
      product = mac_pkg::wide_t'(prod_norm);
    end
  end

  // accumulator adder, wide enough that it cannot overflow
  always_comb begin
    // RULE_02 RULE_09 wide sum
    wide_sum = mac_pkg::wide_t'($signed(operand_d))
             + mac_pkg::wide_t'($signed(c_v))
             + mac_pkg::wide_t'({1'b0, cin_v});
    if (ctrl_v[`MAC_CTL_SUBTRACT]) begin
      wide_sum = wide_sum - product;
    end else begin
      wide_sum = wide_sum + product;
    end
    // RULE_07 RULE_08 flag kind
    if (flag_kind_select) begin
      flag_calc = c_v[`MAC_SIGN_BIT] ^ operand_d[`MAC_SIGN_BIT]
                ^ wide_sum[`MAC_CARRY_BIT];
    end else begin
      flag_calc = (wide_sum[`MAC_TOP_BIT] ^ wide_sum[`MAC_CARRY_BIT])
                | (wide_sum[`MAC_CARRY_BIT] ^ wide_sum[`MAC_SIGN_BIT]);
    end
  end

  // result and flag stage share bypass, clear and enable
  always_comb begin
    // RULE_17 result with flag
    p_stage = stage_next(result_en, result_sync_clear_n, '0,
                         {flag_calc, wide_sum[`MAC_ACC_W-1:0]},
                         {flag_q, p_q});
    flag_d = p_stage[`MAC_ACC_W];
    p_d = p_stage[`MAC_ACC_W-1:0];
  end

  // outputs follow the register unless bypassed; cascade mirrors result
  always_comb begin
    // RULE_10 cascade equals result
    if (!async_clear_n) begin
      result = '0;
      cascade_out = '0;
      overflow_or_carry_flag = 1'b0;
    end else begin
      result = result_bypass ? p_d : p_q;
      cascade_out = result_bypass ? p_d : p_q;
      overflow_or_carry_flag = result_bypass ? flag_d : flag_q;
    end
  end

  // all state on the one clock, cleared asynchronously
  // RULE_12 RULE_13 clock and clear
  always_ff @(posedge clock or negedge async_clear_n) begin
    if (!async_clear_n) begin
      a_q <= '0;
      b_q <= '0;
      c_q <= '0;
      cin_q <= 1'b0;
      p_q <= '0;
      flag_q <= 1'b0;
      ctrl_q <= '0;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
      c_q <= c_d;
      cin_q <= cin_d;
      p_q <= p_d;
      flag_q <= flag_d;
      ctrl_q <= ctrl_d;
    end
  end

  // checks on the datapath and register stages
  default clocking cb @(posedge clock); endclocking
  default disable iff (!async_clear_n);

  property p_d_zero;
    !ctrl_v[`MAC_CTL_CASCADE] && !ctrl_v[`MAC_CTL_FEEDBACK]
      |-> operand_d == '0;
  endproperty
  a_d_zero: assert property (p_d_zero) // RULE_04
    else $error("operand d not zero");

  property p_d_shift;
    ctrl_v[`MAC_CTL_CASCADE] && ctrl_v[`MAC_CTL_SHIFT]
      |-> operand_d == {{`MAC_D_SHIFT{cascade_in[`MAC_SIGN_BIT]}},
                        cascade_in[`MAC_ACC_W-1:`MAC_D_SHIFT]};
  endproperty
  a_d_shift: assert property (p_d_shift) // RULE_05
    else $error("shifted cascade operand wrong");

  property p_cascade;
    cascade_out == result;
  endproperty
  a_cascade: assert property (p_cascade) // RULE_10
    else $error("cascade output differs from result");

  property p_accumulate;
    result_en && result_sync_clear_n && !result_bypass
      |=> result == $past(wide_sum[`MAC_ACC_W-1:0]);
  endproperty
  a_accumulate: assert property (p_accumulate) // RULE_02
    else $error("result did not take the sum");

  property p_hold;
    !result_en && !result_bypass ##1 !result_bypass
      |-> $stable(result) && $stable(p_q);
  endproperty
  a_hold: assert property (p_hold) // RULE_16
    else $error("result changed while disabled");

  property p_clear;
    result_en && !result_sync_clear_n |=> p_q == '0 && !flag_q;
  endproperty
  a_clear: assert property (p_clear) // RULE_17
    else $error("sync clear missed result or flag");

  property p_ovf;
    !flag_kind_select |-> flag_calc ==
      !(wide_sum[`MAC_TOP_BIT:`MAC_SIGN_BIT] inside {3'b000, 3'b111});
  endproperty
  a_ovf: assert property (p_ovf) // RULE_07
    else $error("overflow flag wrong");

  property p_carry;
    flag_kind_select |-> flag_calc == (c_v[`MAC_SIGN_BIT]
      ^ operand_d[`MAC_SIGN_BIT] ^ wide_sum[`MAC_CARRY_BIT]);
  endproperty
  a_carry: assert property (p_carry) // RULE_08
    else $error("carry flag wrong");

  property p_sub_load;
    subtract_en && !subtract_sync_load_n
      |=> ctrl_q[`MAC_CTL_SUBTRACT] == $past(subtract_sync_load_value);
  endproperty
  a_sub_load: assert property (p_sub_load) // RULE_14
    else $error("subtract load value not taken");

  property p_dot;
    dot_product_select && !ctrl_v[`MAC_CTL_SUBTRACT] && c_v == '0
      && !cin_v && operand_d == '0
      |-> wide_sum == (mac_pkg::wide_t'(cross_sum) <<< `MAC_DOT_SHIFT);
  endproperty
  a_dot: assert property (p_dot) // RULE_01
    else $error("dot product sum wrong");

  property p_reset;
    disable iff (1'b0)
    !async_clear_n |-> result == '0 && !overflow_or_carry_flag;
  endproperty
  a_reset: assert property (p_reset) // RULE_13
    else $error("outputs not clear during reset");

  c_feedback: cover property (ctrl_v[`MAC_CTL_FEEDBACK] && result_en);
  c_cascade_shift: cover property (ctrl_v[`MAC_CTL_CASCADE]
                                   && ctrl_v[`MAC_CTL_SHIFT]);
  c_dot_sub: cover property (dot_product_select
                             && ctrl_v[`MAC_CTL_SUBTRACT]);
  c_overflow: cover property (!flag_kind_select && flag_calc);

endmodule : multiply_accumulate_18x18

// ---- dv/cascade_neighbour.sv ----
// upstream accumulator seen through its cascade output
module cascade_neighbour (
  input wire logic clock,
  input wire logic async_clear_n,
  input wire logic load,
  input wire mac_pkg::acc_t value,
  output mac_pkg::acc_t cascade_in
);
  timeunit 1ns;
  timeprecision 1ps;
  mac_pkg::acc_t out_q;
  mac_pkg::acc_t out_d;
  // hold its result unless told to take a new one
  always_comb begin
    out_d = load ? value : out_q;
  end
  always_ff @(posedge clock or negedge async_clear_n) begin
    if (!async_clear_n) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end
  assign cascade_in = out_q;
endmodule : cascade_neighbour

// ---- dv/multiply_accumulate_18x18_bench.sv ----
module multiply_accumulate_18x18_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    mac_pkg::operand_t a, b;
    mac_pkg::acc_t c;
    logic cy, sub, dot, kind;
  } row_t;
  logic clock = 0, async_clear_n = 0, dot_product_select = 0, nb_load = 0;
  logic flag_kind_select = 0, transient_filter_enable = 0, carry_input = 0;
  mac_pkg::operand_t a = '0, b = '0;
  mac_pkg::acc_t c = '0, nb_value = '0;
  wire mac_pkg::acc_t result, cascade_out, cascade_in;
  wire overflow_or_carry_flag;
  logic a_bypass = 1, a_sync_clear_n = 1, a_en = 1;
  logic b_bypass = 1, b_sync_clear_n = 1, b_en = 1;
  logic c_bypass = 1, c_sync_clear_n = 1, c_en = 1;
  logic result_bypass = 1, result_sync_clear_n = 1, result_en = 1;
  logic operand_d_shift = 0, operand_d_shift_bypass = 1;
  logic operand_d_shift_en = 1, operand_d_shift_sync_load_n = 1;
  logic operand_d_shift_sync_load_value = 0, cascade_select = 0;
  logic cascade_select_bypass = 1, cascade_select_en = 1;
  logic cascade_select_sync_load_n = 1, cascade_select_sync_load_value = 0;
  logic feedback_select = 0, feedback_select_bypass = 1;
  logic feedback_select_en = 1, feedback_select_sync_load_n = 1;
  logic feedback_select_sync_load_value = 0, subtract = 0;
  logic subtract_bypass = 1, subtract_en = 1, subtract_sync_load_n = 1;
  logic subtract_sync_load_value = 0;
  int error_cnt = 0, comparisons = 0, cycles = 0;
  // carry on c
  // c low nine bits equal carry in the dot rows
  row_t rows [6] = '{
    '{18'h0_0003, 18'h0_0005, 44'h000_0000_0007, 1'b1, 1'b0, 1'b0, 1'b0},
    '{18'h3_ffff, 18'h0_0010, 44'h000_0000_0000, 1'b0, 1'b1, 1'b0, 1'b0},
    '{18'h3_fe05, 18'h0_0a07, 44'h000_0012_01ff, 1'b1, 1'b0, 1'b1, 1'b0},
    '{18'h2_0bff, 18'h1_f1f3, 44'h800_0000_0000, 1'b0, 1'b1, 1'b1, 1'b1},
    '{18'h0_0001, 18'h0_0001, 44'h7ff_ffff_ffff, 1'b0, 1'b0, 1'b0, 1'b0},
    '{18'h0_0001, 18'h0_0001, 44'hfff_ffff_ffff, 1'b0, 1'b0, 1'b0, 1'b1}};

  multiply_accumulate_18x18 DUT (.*);
  cascade_neighbour nb (.clock, .async_clear_n, .load(nb_load),
    .value(nb_value), .cascade_in);

  // free-running clock, 20 ns period
  always #10 clock = ~clock;

  // reference wide sum, signed operands throughout
  function automatic logic [45:0] wsum(logic [45:0] d, logic sub);
    logic signed [45:0] p;
    p = dot_product_select ? (($signed(a[8:0]) * $signed(b[17:9]) +
      $signed(a[17:9]) * $signed(b[8:0])) <<< 9) : $signed(a) * $signed(b);
    return d + {{2{c[43]}}, c} + carry_input + (sub ? -p : p);
  endfunction : wsum

  task automatic check(input logic [45:0] seen, input logic [45:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic expect_out(input logic [45:0] d, input logic sub);
    logic [45:0] s;
    logic ovf;
    s = wsum(d, sub);
    ovf = (s[45] ^ s[44]) | (s[44] ^ s[43]);
    check(result, s[43:0]);
    check(cascade_out, s[43:0]);
    check(overflow_or_carry_flag,
      flag_kind_select ? c[43] ^ d[43] ^ s[44] : ovf);
  endtask : expect_out

  // inputs move a fixed 1 ns after the rising edge
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick

  task automatic stop_test();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // hang guard, far above the few dozen cycles used
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    repeat (11) tick();
    check(result, '0);
    tick();
    async_clear_n = 1;
    // combinational rows, every stage bypassed, operand d zero
    foreach (rows[i]) begin
      tick();
      {a, b, c, carry_input, subtract, dot_product_select,
        flag_kind_select} = rows[i];
      #2 expect_out('0, subtract);
    end
    // cascade input as operand d, with and without the shift
    nb_value = 44'h876_5432_1000;
    nb_load = 1;
    tick();
    nb_load = 0;
    cascade_select = 1;
    #2 expect_out({{2{nb_value[43]}}, nb_value}, subtract);
    operand_d_shift = 1;
    #2 expect_out(46'($signed(nb_value) >>> 17), subtract);
    // registered accumulate: clear, four adds of 15, then hold
    {a, b, c, carry_input, subtract, dot_product_select} = '0;
    a = 18'h0_0003;
    b = 18'h0_0005;
    {cascade_select, operand_d_shift, result_bypass} = '0;
    feedback_select = 1;
    result_sync_clear_n = 0;
    tick();
    check({result, overflow_or_carry_flag}, '0);
    result_sync_clear_n = 1;
    repeat (4) tick();
    check(result, 44'h000_0000_003c);
    result_en = 0;
    repeat (3) tick();
    check(result, 44'h000_0000_003c);
    // clear lands between edges, no clock needed
    #4 async_clear_n = 0;
    #1 check({result, overflow_or_carry_flag}, '0);
    tick();
    async_clear_n = 1;
    {result_bypass, result_en, feedback_select} = 3'b110;
    // control registers: synchronous load, then hold with enable low
    {operand_d_shift_bypass, cascade_select_bypass} = '0;
    {feedback_select_bypass, subtract_bypass} = '0;
    {operand_d_shift_sync_load_n, cascade_select_sync_load_n} = '0;
    {feedback_select_sync_load_n, subtract_sync_load_n} = '0;
    subtract_sync_load_value = 1;
    tick();
    {operand_d_shift_en, cascade_select_en} = '0;
    {feedback_select_en, subtract_en, subtract_sync_load_n} = '0;
    tick();
    #2 expect_out('0, 1'b1);
    subtract_en = 1;
    subtract_sync_load_n = 1;
    tick();
    #2 expect_out('0, 1'b0);
    // data stages: clear a, b and c, hold, then load
    c = 44'h000_0000_0100;
    {a_bypass, b_bypass, c_bypass} = '0;
    {a_sync_clear_n, b_sync_clear_n, c_sync_clear_n} = '0;
    tick();
    {a_en, b_en, c_en} = '0;
    {a_sync_clear_n, b_sync_clear_n, c_sync_clear_n} = 3'b111;
    tick();
    check(result, '0);
    {a_en, b_en, c_en} = 3'b111;
    tick();
    #2 expect_out('0, 1'b0);
    stop_test();
  end
endmodule : multiply_accumulate_18x18_bench
